// ### src/aao_alu.v
// APB-controlled add and AND datapath with accumulator, flags and a data memory port.
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "aao_map.vh"
module aao_alu #(
   parameter MEM_AW = 10
) (
   input  wire              ref_clk,
   input  wire              rst_b,
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [7:0]        paddr,
   input  wire [31:0]       pwdata,
   input  wire [3:0]        pstrb,
   output wire              pready,
   output wire [31:0]       prdata,
   output wire              pslverr,
   output wire [MEM_AW-1:0] mem_addr,
   output wire              mem_rd_en,
   output wire              mem_wr_en,
   output wire [7:0]        mem_wdata,
   input  wire [7:0]        mem_rdata
);

   // Sequencer states.
   localparam [2:0] ST_IDLE  = 3'h0;
   localparam [2:0] ST_START = 3'h1;
   localparam [2:0] ST_WAIT  = 3'h2;
   localparam [2:0] ST_EXEC  = 3'h3;
   localparam [2:0] ST_DONE  = 3'h4;

   // Software visible state.
   reg  [7:0]        acc_reg;
   reg  [7:0]        imm_reg;
   reg  [MEM_AW-1:0] addr_reg;
   reg  [2:0]        op_reg;
   reg  [4:0]        flags_reg;
   reg  [7:0]        result_reg;

   // Sequencer and memory port state.
   reg  [2:0]        state_reg;
   reg  [2:0]        state_next;
   reg               mem_rd_reg;
   reg               mem_wr_reg;
   reg  [7:0]        mem_wdata_reg;

   // Bus answer state.
   reg               pready_reg;
   reg  [31:0]       prdata_reg;
   reg               pslverr_reg;
   reg  [31:0]       rdata_next;
   reg               hit_next;

   // Operation decode.
   reg               uses_mem;
   reg               uses_carry;
   reg               to_mem;
   reg               is_and;
   wire [7:0]        operand;
   wire [7:0]        and_res;
   wire [7:0]        add_sum;
   wire              add_c;
   wire              add_hc;
   wire              add_wrap;
   wire              add_z;
   wire              add_scond;
   wire              busy;
   wire              setup_phase;
   wire              wr_commit;
   wire              go_write;

   // Every output leaves straight from a flip-flop.
   assign pready    = pready_reg;
   assign prdata    = prdata_reg;
   assign pslverr   = pslverr_reg;
   assign mem_addr  = addr_reg;
   assign mem_rd_en = mem_rd_reg;
   assign mem_wr_en = mem_wr_reg;
   assign mem_wdata = mem_wdata_reg;

   assign busy = (state_reg != ST_IDLE);

   // Setup is recognised once; the registered ready then closes the access a cycle later.
   assign setup_phase = psel & ~penable & ~pready_reg;
   // A write lands only at the completing edge and only if it was not refused.
   assign wr_commit = psel & penable & pready_reg & pwrite & ~pslverr_reg;
   assign go_write  = wr_commit & (paddr == `AAO_OFF_CTRL) & pstrb[1]
                      & pwdata[`AAO_CTRL_GO_BIT];

   // Classify the latched operation.
   always @* begin
      uses_mem   = 1'b1;
      uses_carry = 1'b0;
      to_mem     = 1'b0;
      is_and     = 1'b0;
      case (op_reg)
         `AAO_OP_ADD_MEM: begin
            uses_mem = 1'b1;
         end
         `AAO_OP_ADD_IMM: begin
            uses_mem = 1'b0;
         end
         `AAO_OP_ADC_MEM: begin
            uses_carry = 1'b1;
         end
         `AAO_OP_ADD_INTO_MEMORY: begin
            to_mem = 1'b1;
         end
         `AAO_OP_ADD_WITH_CARRY_TO_MEMORY: begin
            uses_carry = 1'b1;
            to_mem     = 1'b1;
         end
         `AAO_OP_AND_MEM: begin
            is_and = 1'b1;
         end
         `AAO_OP_AND_IMM: begin
            uses_mem = 1'b0;
            is_and   = 1'b1;
         end
         `AAO_OP_AND_INTO_MEMORY: begin
            is_and = 1'b1;
            to_mem = 1'b1;
         end
         default: begin
            uses_mem = 1'b1;
         end
      endcase
   end

   // Second operand: the fetched byte or the immediate constant.
   assign operand = uses_mem ? mem_rdata : imm_reg;
   assign and_res = acc_reg & operand;

   // The carry input is the stored flag, which is not touched until the result is written.
   aao_adder #(
      .W (`AAO_DW)
   ) u_adder (
      .a                    (acc_reg),
      .b                    (operand),
      .cin                  (uses_carry & flags_reg[`AAO_FLAG_C]),
      .sum                  (add_sum),
      .carry                (add_c),
      .half_carry_bit       (add_hc),
      .signed_wrap_bit      (add_wrap),
      .zero                 (add_z),
      .signed_condition_bit (add_scond)
   );

   // Read data and address decode, worked out during the setup cycle.
   always @* begin
      hit_next   = 1'b1;
      rdata_next = 32'h0000_0000;
      case (paddr)
         `AAO_OFF_CTRL: begin
            rdata_next = {29'h0, op_reg};
         end
         `AAO_OFF_ACC: begin
            rdata_next = {24'h00_0000, acc_reg};
         end
         `AAO_OFF_IMM: begin
            rdata_next = {24'h00_0000, imm_reg};
         end
         `AAO_OFF_ADDR: begin
            rdata_next = {{(32 - MEM_AW){1'b0}}, addr_reg};
         end
         `AAO_OFF_STATUS: begin
            rdata_next = {23'h00_0000, busy, 3'h0, flags_reg};
         end
         `AAO_OFF_RESULT: begin
            rdata_next = {24'h00_0000, result_reg};
         end
         default: begin
            hit_next = 1'b0;
         end
      endcase
   end

   // APB answer: no wait state on any access, error on unmapped or busy writes.
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         pready_reg  <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else if (setup_phase) begin
         pready_reg  <= 1'b1;
         prdata_reg  <= pwrite ? 32'h0000_0000 : rdata_next;
         // Writes during an operation are refused so software never races the datapath.
         pslverr_reg <= ~hit_next | (pwrite & busy);
      end else begin
         pready_reg  <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end
   end

   // Software registers, plus the result write of the datapath itself.
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         acc_reg    <= `AAO_ACC_RST;
         imm_reg    <= `AAO_IMM_RST;
         addr_reg   <= {MEM_AW{1'b0}};
         op_reg     <= `AAO_OP_RST;
         flags_reg  <= `AAO_FLAGS_RST;
         result_reg <= 8'h00;
      end else if (state_reg == ST_EXEC) begin
         if (is_and) begin
            result_reg <= and_res;
            if (!to_mem) begin
               acc_reg <= and_res;
            end
            // Only zero moves; the four arithmetic flags hold their values.
            flags_reg[`AAO_FLAG_Z] <= ~|and_res;
         end else begin
            result_reg <= add_sum;
            if (!to_mem) begin
               acc_reg <= add_sum;
            end
            flags_reg[`AAO_FLAG_C]           <= add_c;
            flags_reg[`AAO_FLAG_HALF_CARRY]  <= add_hc;
            flags_reg[`AAO_FLAG_Z]           <= add_z;
            flags_reg[`AAO_FLAG_SIGNED_WRAP] <= add_wrap;
            flags_reg[`AAO_FLAG_SIGNED_COND] <= add_scond;
         end
      end else if (wr_commit) begin
         case (paddr)
            `AAO_OFF_CTRL: begin
               if (pstrb[0]) begin
                  op_reg <= pwdata[`AAO_CTRL_OP_MSB:`AAO_CTRL_OP_LSB];
               end
            end
            `AAO_OFF_ACC: begin
               if (pstrb[0]) begin
                  acc_reg <= pwdata[7:0];
               end
            end
            `AAO_OFF_IMM: begin
               if (pstrb[0]) begin
                  imm_reg <= pwdata[7:0];
               end
            end
            `AAO_OFF_ADDR: begin
               if (pstrb[0]) begin
                  addr_reg[7:0] <= pwdata[7:0];
               end
               if (pstrb[1]) begin
                  addr_reg[MEM_AW-1:8] <= pwdata[MEM_AW-1:8];
               end
            end
            `AAO_OFF_STATUS: begin
               if (pstrb[0]) begin
                  flags_reg <= pwdata[4:0];
               end
            end
            default: begin
               result_reg <= result_reg;
            end
         endcase
      end
   end

   // Sequencer transitions; a start request waits one cycle so the new op code is latched.
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (go_write) begin
               state_next = ST_START;
            end
         end
         ST_START: begin
            state_next = uses_mem ? ST_WAIT : ST_EXEC;
         end
         ST_WAIT: begin
            state_next = ST_EXEC;
         end
         ST_EXEC: begin
            state_next = ST_DONE;
         end
         ST_DONE: begin
            state_next = ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // Memory port: a one-cycle read strobe, then a one-cycle write strobe for memory results.
   // The memory must present read data the cycle after the strobe; no longer latency is allowed.
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         state_reg     <= ST_IDLE;
         mem_rd_reg    <= 1'b0;
         mem_wr_reg    <= 1'b0;
         mem_wdata_reg <= 8'h00;
      end else begin
         state_reg  <= state_next;
         mem_rd_reg <= (state_reg == ST_START) & uses_mem;
         mem_wr_reg <= (state_reg == ST_EXEC) & to_mem;
         if ((state_reg == ST_EXEC) && to_mem) begin
            mem_wdata_reg <= is_and ? and_res : add_sum;
         end
      end
   end

endmodule // aao_alu
`default_nettype wire

// ### src/aao_map.vh
// Register offsets, field positions, reset values and operation codes of the add/AND datapath.
`ifndef AAO_MAP_VH
`define AAO_MAP_VH
// Contract
// - Carry add: accumulator plus byte plus carry.
// - Carry add result goes back to memory.
// - Carry input is the flag before execution.
// - Memory add into accumulator, no carry.
// - Immediate add into accumulator, no carry.
// - Memory add result goes to memory.
// - Every add updates five status flags.
// - Memory AND into the accumulator.
// - Immediate AND into the accumulator.
// - Memory AND result goes to memory.
// - AND updates zero only, others kept.

// Data width of the datapath.
`define AAO_DW            8

// Register byte addresses on the APB bus.
`define AAO_OFF_CTRL      8'h00
`define AAO_OFF_ACC       8'h04
`define AAO_OFF_IMM       8'h08
`define AAO_OFF_ADDR      8'h0c
`define AAO_OFF_STATUS    8'h10
`define AAO_OFF_RESULT    8'h14

// Control register fields.
`define AAO_CTRL_OP_LSB   0
`define AAO_CTRL_OP_MSB   2
`define AAO_CTRL_GO_BIT   8

// Status register fields; flags occupy bits 4:0.
`define AAO_FLAG_C           0
`define AAO_FLAG_HALF_CARRY  1
`define AAO_FLAG_Z           2
`define AAO_FLAG_SIGNED_WRAP 3
`define AAO_FLAG_SIGNED_COND 4
`define AAO_STAT_BUSY_BIT 8

// Reset values.
`define AAO_ACC_RST       8'h00
`define AAO_IMM_RST       8'h00
`define AAO_FLAGS_RST     5'h00
`define AAO_OP_RST        3'h0

// Operation codes written to the control register.
`define AAO_OP_ADD_MEM           3'h0
`define AAO_OP_ADD_IMM           3'h1
`define AAO_OP_ADC_MEM           3'h2
`define AAO_OP_ADD_INTO_MEMORY   3'h3
`define AAO_OP_ADD_WITH_CARRY_TO_MEMORY 3'h4
`define AAO_OP_AND_MEM           3'h5
`define AAO_OP_AND_IMM           3'h6
`define AAO_OP_AND_INTO_MEMORY   3'h7

`endif

// ### src/aao_adder.v
// Eight-bit style adder with carry-in that produces the sum and all arithmetic flags.
`timescale 1ns/10ps
`default_nettype none
module aao_adder #(
   parameter W = 8
) (
   input  wire [W-1:0] a,
   input  wire [W-1:0] b,
   input  wire         cin,
   output wire [W-1:0] sum,
   output wire         carry,
   output wire         half_carry_bit,
   output wire         signed_wrap_bit,
   output wire         zero,
   output wire         signed_condition_bit
);

   wire [W:0] full_sum;
   wire [4:0] low_sum;

   // Full and low-nibble sums; the carry enters both so the half carry sees it too.
   assign full_sum = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
   assign low_sum  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};

   // Flags from the sums.
   assign sum            = full_sum[W-1:0];
   assign carry          = full_sum[W];
   assign half_carry_bit = low_sum[4];
   assign zero           = ~|full_sum[W-1:0];
   // Overflow when both inputs share a sign that the result does not.
   assign signed_wrap_bit = (a[W-1] == b[W-1]) & (full_sum[W-1] != a[W-1]);
   // The signed condition is the sign the exact result would have had.
   assign signed_condition_bit = signed_wrap_bit ^ full_sum[W-1];

endmodule // aao_adder
`default_nettype wire

// ### tb/aao_alu_asserts.sv
// Concurrent checks on the ports of the add and AND datapath.
`timescale 1ns/10ps
`default_nettype none
module aao_alu_asserts #(
   parameter MEM_AW = 10
) (
   input wire logic              ref_clk,
   input wire logic              rst_b,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [7:0]        paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [3:0]        pstrb,
   input wire logic              pready,
   input wire logic [31:0]       prdata,
   input wire logic              pslverr,
   input wire logic [MEM_AW-1:0] mem_addr,
   input wire logic              mem_rd_en,
   input wire logic              mem_wr_en,
   input wire logic [7:0]        mem_wdata,
   input wire logic [7:0]        mem_rdata
);
   // All checks live in the one clock domain.
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   setup_ready_a: assert property (psel && !penable |=> pready) else $error("ready late");
   ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("stray read data");
   unmapped_err_a: assert property (pready && paddr > 8'h14 |-> pslverr && prdata == 32'h0)
      else $error("unmapped accepted");
   rd_pulse_a: assert property (mem_rd_en |=> !mem_rd_en ##1 !mem_rd_en) else $error("rd held");
   wr_after_rd_a: assert property (mem_wr_en |-> $past(mem_rd_en, 2) && !$past(mem_wr_en))
      else $error("write without read");
   wr_addr_hold_a: assert property (mem_wr_en |-> mem_addr == $past(mem_addr, 2))
      else $error("write address moved");
   // Reset itself moves the write data, so the edges just after a release are left out.
   wdata_hold_a: assert property (!mem_wr_en && $past(rst_b) |-> mem_wdata == $past(mem_wdata))
      else $error("write data moved");
   no_rd_wr_a: assert property (!(mem_rd_en && mem_wr_en)) else $error("read and write together");
   // Main scenarios seen at least once.
   wr_seen_c: cover property (mem_wr_en);
   rd_seen_c: cover property (mem_rd_en);
   err_seen_c: cover property (pready && pslverr);
endmodule // aao_alu_asserts
bind aao_alu aao_alu_asserts #(.MEM_AW(MEM_AW)) u_aao_alu_asserts (
   .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
   .pslverr(pslverr), .mem_addr(mem_addr), .mem_rd_en(mem_rd_en), .mem_wr_en(mem_wr_en),
   .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
`default_nettype wire

// ### tb/aao_mem_model.sv
// Behavioural data memory behind the datapath's memory port.
`timescale 1ns/10ps
`default_nettype none
module aao_mem_model (
   input  wire logic       ref_clk,
   input  wire logic [9:0] mem_addr,
   input  wire logic       mem_rd_en,
   input  wire logic       mem_wr_en,
   input  wire logic [7:0] mem_wdata,
   output var  logic [7:0] mem_rdata
);
   logic [7:0] mem_arr [0:1023];
   initial mem_rdata = 8'h00;
   // Data is valid only the cycle after a strobe; otherwise the lines flip so a late sample fails.
   always @(posedge ref_clk) begin
      if (mem_rd_en === 1'b1) mem_rdata <= mem_arr[mem_addr];
      else mem_rdata <= ~mem_rdata;
      if (mem_wr_en === 1'b1) mem_arr[mem_addr] <= mem_wdata;
   end
endmodule // aao_mem_model
`default_nettype wire

// ### tb/aao_alu_tb_top.sv
// Self-checking bench for the add and AND datapath.
`timescale 1ns/10ps
`default_nettype none
`include "aao_map.vh"
module aao_alu_tb_top;
   logic        ref_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'hf;
   wire         pready;
   wire  [31:0] prdata;
   wire         pslverr;
   wire  [9:0]  mem_addr;
   wire         mem_rd_en;
   wire         mem_wr_en;
   wire  [7:0]  mem_wdata;
   wire  [7:0]  mem_rdata;
   int          num_errors = 0;
   int          total_checks = 0;
   integer      seed = 32'hb7f13275;
   logic [33:0] apb_q[$];
   logic [17:0] mem_q[$];
   logic [33:0] note;
   logic [17:0] mnote;
   always #50 ref_clk = ~ref_clk;
   aao_alu #(.MEM_AW(10)) u_aao_alu (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .mem_addr(mem_addr),
      .mem_rd_en(mem_rd_en), .mem_wr_en(mem_wr_en), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata));
   aao_mem_model u_aao_mem_model (.ref_clk(ref_clk), .mem_addr(mem_addr),
      .mem_rd_en(mem_rd_en), .mem_wr_en(mem_wr_en), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata));
   task automatic report_and_stop;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One APB transfer; the note says what the watcher should see when ready comes.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [33:0] nt, output logic [31:0] rd);
      int n;
      apb_q.push_back(nt);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge ref_clk);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         num_errors++;
         report_and_stop;
      end
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic err);
      logic [31:0] v;
      apb(1'b1, a, d, {1'b0, err, 32'h0}, v);
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp, input logic err);
      logic [31:0] v;
      apb(1'b0, a, 32'h0, {1'b1, err, exp}, v);
   endtask
   // Polls busy under a bound; the poll reads themselves carry no data expectation.
   task automatic wait_idle;
      logic [31:0] v;
      int n;
      v = 32'h100;
      for (n = 0; n < 20 && v[8] !== 1'b0; n++) apb(1'b0, `AAO_OFF_STATUS, 32'h0, 34'h0, v);
      if (v[8] !== 1'b0) begin
         num_errors++;
         report_and_stop;
      end
   endtask
   // Watcher: takes the oldest note off a queue whenever the design answers.
   always @(posedge ref_clk) begin
      if (psel && penable && pready === 1'b1) begin
         note = apb_q.pop_front();
         cmp("pslverr", {31'h0, note[32]}, {31'h0, pslverr});
         if (note[33]) cmp("prdata", note[31:0], prdata);
      end
      if (mem_wr_en === 1'b1) begin
         mnote = mem_q.pop_front();
         cmp("mem write", {14'h0, mnote}, {14'h0, mem_addr, mem_wdata});
      end
   end
   initial begin
      int i;
      logic [2:0] op;
      logic [7:0] a, im, m, b, r;
      logic [4:0] fl, nf, hs;
      logic [8:0] s9;
      logic [9:0] ad;
      logic ci, wrap, dm, rd_mem;
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      for (i = 0; i < 6; i++) rd_reg(8'(i * 4), 32'h0, 1'b0);
      rd_reg(8'h18, 32'h0, 1'b1);
      wr_reg(8'h40, 32'hffff_ffff, 1'b1);
      for (i = 0; i < 24; i++) begin
         op = i[2:0];
         a = $random(seed);
         im = $random(seed);
         m = $random(seed);
         fl = $random(seed);
         ad = $random(seed);
         u_aao_mem_model.mem_arr[ad] = m;
         wr_reg(`AAO_OFF_ACC, {24'h0, a}, 1'b0);
         wr_reg(`AAO_OFF_IMM, {24'h0, im}, 1'b0);
         wr_reg(`AAO_OFF_ADDR, {22'h0, ad}, 1'b0);
         wr_reg(`AAO_OFF_STATUS, {27'h0, fl}, 1'b0);
         rd_mem = !(op == 3'h1 || op == 3'h6);
         b = rd_mem ? m : im;
         ci = (op == 3'h2 || op == 3'h4) ? fl[0] : 1'b0;
         dm = (op == 3'h3 || op == 3'h4 || op == 3'h7);
         // Flag model: carry out of bit 7, half carry out of bit 3, signed wrap on sign change.
         if (op < 3'h5) begin
            s9 = a + b + ci;
            r = s9[7:0];
            hs = a[3:0] + b[3:0] + ci;
            wrap = (a[7] == b[7]) && (r[7] != a[7]);
            nf = {wrap ^ r[7], wrap, r == 8'h00, hs[4], s9[8]};
         end else begin
            r = a & b;
            nf = {fl[4:3], r == 8'h00, fl[1:0]};
         end
         if (dm) mem_q.push_back({ad, r});
         wr_reg(`AAO_OFF_CTRL, {23'h0, 1'b1, 5'h0, op}, 1'b0);
         if (rd_mem) wr_reg(`AAO_OFF_ACC, 32'h0000_005a, 1'b1);
         wait_idle;
         rd_reg(`AAO_OFF_ACC, {24'h0, dm ? a : r}, 1'b0);
         rd_reg(`AAO_OFF_STATUS, {27'h0, nf}, 1'b0);
         rd_reg(`AAO_OFF_RESULT, {24'h0, r}, 1'b0);
      end
      wr_reg(`AAO_OFF_RESULT, 32'h0000_00ff, 1'b0);
      rd_reg(`AAO_OFF_RESULT, {24'h0, r}, 1'b0);
      rd_reg(`AAO_OFF_CTRL, {29'h0, op}, 1'b0);
      // Second reset in mid-run, then byte lanes: a cleared lane keeps its byte and blocks go.
      rst_b <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      rd_reg(`AAO_OFF_ACC, 32'h0, 1'b0);
      rd_reg(`AAO_OFF_STATUS, 32'h0, 1'b0);
      pstrb <= 4'h1;
      wr_reg(`AAO_OFF_CTRL, 32'h0000_0101, 1'b0);
      pstrb <= 4'he;
      wr_reg(`AAO_OFF_ACC, 32'h0000_00c3, 1'b0);
      pstrb <= 4'hf;
      rd_reg(`AAO_OFF_STATUS, 32'h0, 1'b0);
      rd_reg(`AAO_OFF_ACC, 32'h0, 1'b0);
      rd_reg(`AAO_OFF_CTRL, 32'h1, 1'b0);
      repeat (4) @(posedge ref_clk);
      report_and_stop;
   end
endmodule // aao_alu_tb_top
`default_nettype wire
